/* File: hw/pdst_pkg.sv */
// Package of constants and types for the process dwell/soft-start timer
package pdst_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int PDST_PV_W = 16;
	localparam int PDST_PWR_W = 8;
	localparam int PDST_TIME_W = 16;
	localparam int PDST_EVT_N = 4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint PDST_CLK_HZ = 100000000;
	localparam longint PDST_TICK_S = 60;
	localparam longint PDST_TICK_CYC = PDST_CLK_HZ * PDST_TICK_S;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PDST_TYPE_OFF,
		PDST_TYPE_DWELL,
		PDST_TYPE_DELAY,
		PDST_TYPE_SOFT
	} pdst_type_t;

	typedef enum logic [1:0] {
		PDST_END_STANDBY,
		PDST_END_CONTINUE,
		PDST_END_SP2,
		PDST_END_RESET
	} pdst_end_t;

	typedef enum logic [1:0] {
		PDST_STAT_RESET,
		PDST_STAT_RUN,
		PDST_STAT_END
	} pdst_stat_t;

	// Resolution: 0 = hours/minutes, 1 = minutes/seconds
	localparam logic PDST_RES_HM = 1'h0;
	localparam logic [PDST_PWR_W-1:0] PDST_PWR_ZERO = 8'h00;
	localparam logic [PDST_PWR_W-1:0] PDST_PWR_FULL = 8'h64;
endpackage : pdst_pkg

/* File: hw/pdst_tick.sv */
// Prescaler making the timer count tick
module pdst_tick #(
	parameter longint DIV = pdst_pkg::PDST_TICK_CYC
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Control
	input wire logic i_clear,
	output logic o_tick
);
	import pdst_pkg::*;

	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	// Refuse a divider the counter cannot serve
	if (DIV < 1) begin : g_bad_div
		$error("pdst_tick: DIV must be at least 1");
	end

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic next_tick;

	// Next count and tick
	always_comb begin
		next_count = count + CW'(1);
		next_tick = 1'b0;
		if (i_clear) begin
			next_count = '0;
		end else if (count == LAST) begin
			next_count = '0;
			next_tick = 1'b1;
		end
	end

	// Register
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			count <= '0;
			o_tick <= 1'b0;
		end else begin
			count <= next_count;
			o_tick <= next_tick;
		end
	end
endmodule : pdst_tick

/* File: hw/pdst_timer.sv */
// Sequencing timer: dwell, delayed switch-on and soft-start
// Functional notes
// - Four timer types; off type holds the timer in reset status
// - Dwell counts only once PV reaches threshold
// - Delay starts at power-up or run command
// - Delay running holds standby, then target setpoint
// - Soft start clamps power until soft setpoint
// - Hours/minutes resolution after reset, then follows the resolution select each cycle
// - End action applies to dwell type only
// - Standby end: zero power, off indication
// - Continue end: keep controlling at setpoint
// - Second-setpoint end: switch target, maybe ramp
// - With rate limit on, status stays run until second setpoint reached
// - Reset end: revert to starting setpoint
// - Events 1-4 assert on run or end
module pdst_timer #(
	parameter longint TICK_DIV = pdst_pkg::PDST_TICK_CYC,
	parameter int EVT_N = pdst_pkg::PDST_EVT_N
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Configuration
	input wire pdst_pkg::pdst_type_t i_timer_type_select,
	input wire logic i_timer_resolution_select,
	input wire pdst_pkg::pdst_end_t i_timer_end_action,
	input wire logic [pdst_pkg::PDST_TIME_W-1:0] i_duration,
	input wire logic [pdst_pkg::PDST_PV_W-1:0] i_start_threshold,
	input wire logic [pdst_pkg::PDST_PWR_W-1:0] i_soft_start_power_limit,
	input wire logic [pdst_pkg::PDST_PV_W-1:0] i_soft_start_setpoint,
	input wire logic i_setpoint_rate_limit_en,
	input wire logic [EVT_N-1:0] i_event_en,
	input wire logic [EVT_N-1:0] i_event_on_end,
	// Operator commands (from same-clock logic)
	input wire logic i_run_cmd,
	input wire logic i_reset_cmd,
	// Process side
	input wire logic [pdst_pkg::PDST_PV_W-1:0] i_process_value,
	input wire logic i_second_setpoint_choice,
	input wire logic i_sp2_reached,
	input wire logic [pdst_pkg::PDST_PWR_W-1:0] i_demand,
	// Outputs
	output logic [pdst_pkg::PDST_PWR_W-1:0] o_demand,
	output logic o_standby,
	output logic o_off_indication,
	output logic o_use_second_setpoint,
	output logic o_ramp_to_sp2,
	output pdst_pkg::pdst_stat_t o_status,
	output logic [pdst_pkg::PDST_TIME_W-1:0] o_elapsed,
	output logic o_time_hm,
	output logic [EVT_N-1:0] o_event
);
	import pdst_pkg::*;

	// Refuse event counts the output logic cannot serve
	if (EVT_N < 1 || EVT_N > PDST_EVT_N) begin : g_bad_evt
		$error("pdst_timer: bad EVT_N");
	end

	// ------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------
	logic tick;
	logic tick_clear;

	pdst_tick #(.DIV(TICK_DIV)) u_tick (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_clear(tick_clear),
		.o_tick(tick)
	);

	// ------------------------------------------------------------
	// Sequence state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PDST_S_POWERUP,
		PDST_S_IDLE,
		PDST_S_ARMED,
		PDST_S_COUNT,
		PDST_S_RAMP,
		PDST_S_DONE,
		PDST_S_SOFT
	} pdst_state_t;

	pdst_state_t state;
	pdst_state_t next_state;
	logic [PDST_TIME_W-1:0] elapsed;
	logic [PDST_TIME_W-1:0] next_elapsed;
	logic start_sp2;
	logic next_start_sp2;
	logic done_standby;
	logic next_done_standby;
	logic use_sp2;
	logic next_use_sp2;

	function automatic logic expired(input logic [PDST_TIME_W-1:0] t,
		input logic [PDST_TIME_W-1:0] d);
		expired = (t >= d);
	endfunction : expired

	// Next state of the sequence
	always_comb begin
		next_state = state;
		next_elapsed = elapsed;
		next_start_sp2 = start_sp2;
		next_done_standby = done_standby;
		next_use_sp2 = use_sp2;
		tick_clear = 1'b0;
		case (state)
			PDST_S_POWERUP: begin
				next_use_sp2 = i_second_setpoint_choice;
				next_start_sp2 = i_second_setpoint_choice;
				tick_clear = 1'b1;
				next_elapsed = '0;
				case (i_timer_type_select)
					PDST_TYPE_DELAY: next_state = PDST_S_COUNT;
					PDST_TYPE_SOFT: next_state = PDST_S_SOFT;
					default: next_state = PDST_S_IDLE;
				endcase
			end
			PDST_S_IDLE: begin
				tick_clear = 1'b1;
				next_elapsed = '0;
				next_done_standby = 1'b0;
				if (i_run_cmd) begin
					next_start_sp2 = use_sp2;
					case (i_timer_type_select)
						PDST_TYPE_DWELL: next_state = PDST_S_ARMED;
						PDST_TYPE_DELAY: next_state = PDST_S_COUNT;
						PDST_TYPE_SOFT: next_state = PDST_S_SOFT;
						default: next_state = PDST_S_IDLE;
					endcase
				end
			end
			PDST_S_ARMED: begin
				tick_clear = 1'b1;
				if (i_process_value >= i_start_threshold) begin
					next_state = PDST_S_COUNT;
				end
			end
			PDST_S_COUNT: begin
				if (tick) begin
					next_elapsed = elapsed + PDST_TIME_W'(1);
				end
				if (expired(elapsed, i_duration)) begin
					next_state = PDST_S_DONE;
					if (i_timer_type_select == PDST_TYPE_DWELL) begin
						case (i_timer_end_action)
							PDST_END_STANDBY: next_done_standby = 1'b1;
							PDST_END_CONTINUE: next_state = PDST_S_DONE;
							PDST_END_SP2: begin
								next_use_sp2 = 1'b1;
								next_state = PDST_S_RAMP;
							end
							PDST_END_RESET: begin
								next_use_sp2 = start_sp2;
								next_state = PDST_S_IDLE;
							end
							default: next_state = PDST_S_DONE;
						endcase
					end
				end
			end
			PDST_S_RAMP: begin
				if (!i_setpoint_rate_limit_en || i_sp2_reached) begin
					next_state = PDST_S_DONE;
				end
			end
			PDST_S_SOFT: begin
				if (i_process_value >= i_soft_start_setpoint) begin
					next_state = PDST_S_DONE;
				end
			end
			PDST_S_DONE: begin
			end
			default: next_state = PDST_S_IDLE;
		endcase
		if (i_reset_cmd && state != PDST_S_POWERUP) begin
			next_state = PDST_S_IDLE;
			next_done_standby = 1'b0;
		end
		if (i_timer_type_select == PDST_TYPE_OFF) begin
			next_state = PDST_S_IDLE;
			next_done_standby = 1'b0;
		end
	end

	// Registers of the sequence
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state <= PDST_S_POWERUP;
			elapsed <= '0;
			start_sp2 <= 1'b0;
			done_standby <= 1'b0;
			use_sp2 <= 1'b0;
		end else begin
			state <= next_state;
			elapsed <= next_elapsed;
			start_sp2 <= next_start_sp2;
			done_standby <= next_done_standby;
			use_sp2 <= next_use_sp2;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic [PDST_PWR_W-1:0] next_demand;
	logic next_standby;
	pdst_stat_t next_status;
	logic [EVT_N-1:0] next_event;

	// Output demand, standby and status
	always_comb begin
		next_standby = 1'b0;
		next_demand = i_demand;
		case (next_state)
			PDST_S_IDLE, PDST_S_POWERUP: next_status = PDST_STAT_RESET;
			PDST_S_DONE: next_status = PDST_STAT_END;
			default: next_status = PDST_STAT_RUN;
		endcase
		if (next_state == PDST_S_COUNT &&
			i_timer_type_select == PDST_TYPE_DELAY) begin
			next_standby = 1'b1;
		end
		if (next_done_standby) begin
			next_standby = 1'b1;
		end
		if (next_state == PDST_S_SOFT && i_demand > i_soft_start_power_limit) begin
			next_demand = i_soft_start_power_limit;
		end
		if (next_standby) begin
			next_demand = PDST_PWR_ZERO;
		end
		for (int i = 0; i < EVT_N; i++) begin
			next_event[i] = i_event_en[i] && (i_event_on_end[i] ?
				(next_status == PDST_STAT_END) :
				(next_status == PDST_STAT_RUN));
		end
	end

	// Output registers
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_demand <= PDST_PWR_ZERO;
			o_standby <= 1'b0;
			o_off_indication <= 1'b0;
			o_use_second_setpoint <= 1'b0;
			o_ramp_to_sp2 <= 1'b0;
			o_status <= PDST_STAT_RESET;
			o_elapsed <= '0;
			o_time_hm <= PDST_RES_HM;
			o_event <= '0;
		end else begin
			o_demand <= next_demand;
			o_standby <= next_standby;
			o_off_indication <= next_done_standby;
			o_use_second_setpoint <= next_use_sp2;
			o_ramp_to_sp2 <= (next_state == PDST_S_RAMP) &&
				i_setpoint_rate_limit_en;
			o_status <= next_status;
			o_elapsed <= next_elapsed;
			o_time_hm <= i_timer_resolution_select;
			o_event <= next_event;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_off_idle;
		@(posedge i_clock) disable iff (i_rst)
		i_timer_type_select == PDST_TYPE_OFF |=> o_status == PDST_STAT_RESET;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("off type not reset");

	property p_dwell_wait;
		@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_ARMED && i_process_value < i_start_threshold
		&& !i_reset_cmd && i_timer_type_select == PDST_TYPE_DWELL
		|=> state == PDST_S_ARMED && elapsed == $past(elapsed);
	endproperty
	a_dwell_wait: assert property (p_dwell_wait) else $error("dwell early");

	property p_delay_standby;
		@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_COUNT && i_timer_type_select == PDST_TYPE_DELAY
		|-> o_standby && o_demand == PDST_PWR_ZERO;
	endproperty
	a_delay_standby: assert property (p_delay_standby) else $error("no standby");

	property p_soft_clamp;
		@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_SOFT |-> o_demand <= $past(i_soft_start_power_limit);
	endproperty
	a_soft_clamp: assert property (p_soft_clamp) else $error("clamp fail");

	property p_standby_end;
		@(posedge i_clock) disable iff (i_rst)
		o_off_indication |-> o_standby && o_demand == PDST_PWR_ZERO;
	endproperty
	a_standby_end: assert property (p_standby_end) else $error("end power");

	property p_ramp_run;
		@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_RAMP |-> o_status == PDST_STAT_RUN && o_use_second_setpoint;
	endproperty
	a_ramp_run: assert property (p_ramp_run) else $error("ramp status");

	property p_reset_revert;
		@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_COUNT && next_state == PDST_S_IDLE && !i_reset_cmd
		&& i_timer_type_select == PDST_TYPE_DWELL
		|=> use_sp2 == $past(start_sp2);
	endproperty
	a_reset_revert: assert property (p_reset_revert) else $error("revert");

	property p_event_end;
		@(posedge i_clock) disable iff (i_rst)
		o_status == PDST_STAT_END
		|-> o_event == ($past(i_event_en) & $past(i_event_on_end));
	endproperty
	a_event_end: assert property (p_event_end) else $error("event");

	property p_tick_count;
		@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_COUNT && tick && !expired(elapsed, i_duration)
		&& !i_reset_cmd && i_timer_type_select != PDST_TYPE_OFF
		|=> elapsed == $past(elapsed) + PDST_TIME_W'(1);
	endproperty
	a_tick_count: assert property (p_tick_count) else $error("tick");

	c_dwell_end: cover property (@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_COUNT ##1 state == PDST_S_DONE);
	c_ramp: cover property (@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_RAMP ##1 state == PDST_S_DONE);
	c_soft: cover property (@(posedge i_clock) disable iff (i_rst)
		state == PDST_S_SOFT ##1 state == PDST_S_DONE);
endmodule : pdst_timer

/* File: tb/pdst_plant.sv */
// Process and power stage model feeding the measured value
module pdst_plant #(
	parameter logic [pdst_pkg::PDST_PV_W-1:0] SECOND_LEVEL = 16'h0080
) (
	// Clock and preset
	input wire logic i_clock,
	input wire logic i_load,
	input wire logic [pdst_pkg::PDST_PV_W-1:0] i_load_value,
	// Power stage
	input wire logic [pdst_pkg::PDST_PWR_W-1:0] i_power,
	input wire logic i_standby,
	input wire logic i_use_second,
	// Measurement
	output logic [pdst_pkg::PDST_PV_W-1:0] o_pv,
	output logic o_second_reached
);
	timeunit 1ns;
	timeprecision 1ps;
	import pdst_pkg::*;

	// Heat rises one step a cycle under any nonzero power outside standby
	always_ff @(posedge i_clock) begin
		if (i_load) begin
			o_pv <= i_load_value;
		end else if (i_power != PDST_PWR_ZERO && !i_standby) begin
			o_pv <= o_pv + 16'h0001;
		end
	end

	// Second target counts as met once the value passes it
	assign o_second_reached = i_use_second && (o_pv >= SECOND_LEVEL);
endmodule : pdst_plant

/* File: tb/pdst_timer_bench.sv */
// Self-checking bench for the sequencing timer
module pdst_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import pdst_pkg::*;

	// --------
	// Stimulus and observed signals
	// --------
	logic i_clock = 1'h0;
	logic i_rst = 1'h1;
	pdst_type_t ttype = PDST_TYPE_OFF;
	pdst_end_t eact = PDST_END_STANDBY;
	logic res = 1'h0, rate = 1'h1, choice = 1'h0, run = 1'h0;
	logic rcmd = 1'h0, load = 1'h1, use2, ramp, stby, off, hm, sec_ok;
	logic [15:0] dur = 16'h0003, elap, pv;
	logic [7:0] dem = 8'h00, odem;
	logic [3:0] evt, evt_en = 4'hb, evt_end = 4'h3;
	pdst_stat_t stat;
	int n_fail = 0, n_compared = 0, cyc = 0;

	// Clock and hang guard
	always #5 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 8000) begin
			n_fail++;
			complete_run();
		end
	end

	pdst_timer #(.TICK_DIV(4)) dut (
		.i_clock(i_clock), .i_rst(i_rst),
		.i_timer_type_select(ttype), .i_timer_resolution_select(res),
		.i_timer_end_action(eact), .i_duration(dur),
		.i_start_threshold(16'h000a),
		.i_soft_start_power_limit(8'h19),
		.i_soft_start_setpoint(16'h0040),
		.i_setpoint_rate_limit_en(rate), .i_event_en(evt_en),
		.i_event_on_end(evt_end), .i_run_cmd(run), .i_reset_cmd(rcmd),
		.i_process_value(pv), .i_second_setpoint_choice(choice),
		.i_sp2_reached(sec_ok), .i_demand(dem), .o_demand(odem),
		.o_standby(stby), .o_off_indication(off),
		.o_use_second_setpoint(use2), .o_ramp_to_sp2(ramp),
		.o_status(stat), .o_elapsed(elap), .o_time_hm(hm),
		.o_event(evt));

	pdst_plant plant (
		.i_clock(i_clock), .i_load(load), .i_load_value(16'h0000),
		.i_power(odem), .i_standby(stby), .i_use_second(use2),
		.o_pv(pv), .o_second_reached(sec_ok));

	// --------
	// Shared tasks
	// --------
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic wait_stat(input pdst_stat_t s, input int lim);
		int k;
		k = 0;
		while (stat !== s && k < lim) begin
			@(posedge i_clock);
			#1;
			k++;
		end
	endtask : wait_stat

	task automatic start(input pdst_type_t t, input pdst_end_t a,
		input logic c, input logic [7:0] d);
		@(posedge i_clock);
		i_rst <= 1'h1;
		load <= 1'h1;
		ttype <= t;
		eact <= a;
		choice <= c;
		dem <= d;
		res <= 1'h0;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'h0;
		load <= 1'h0;
		repeat (2) @(posedge i_clock);
		#1;
	endtask : start

	task automatic pulse_run();
		@(posedge i_clock);
		run <= 1'h1;
		@(posedge i_clock);
		run <= 1'h0;
		repeat (20) @(posedge i_clock);
		#1;
	endtask : pulse_run

	// --------
	// Scenarios
	// --------
	task automatic t_off();
		start(PDST_TYPE_OFF, PDST_END_STANDBY, 1'h0, 8'h32);
		chk("hm", 16'h0000, 16'(hm));
		@(posedge i_clock);
		res <= 1'h1;
		pulse_run();
		chk("status", PDST_STAT_RESET, stat);
		chk("hm", 16'h0001, 16'(hm));
	endtask : t_off

	// Operator reset aborts a delay, run restarts it
	task automatic t_abort();
		start(PDST_TYPE_DELAY, PDST_END_STANDBY, 1'h0, 8'h32);
		@(posedge i_clock);
		rcmd <= 1'h1;
		@(posedge i_clock);
		rcmd <= 1'h0;
		@(posedge i_clock);
		#1;
		chk("status", PDST_STAT_RESET, stat);
		chk("standby", 16'h0000, 16'(stby));
		@(posedge i_clock);
		run <= 1'h1;
		@(posedge i_clock);
		run <= 1'h0;
		#1;
		chk("status", PDST_STAT_RUN, stat);
		chk("standby", 16'h0001, 16'(stby));
		chk("elapsed", 16'h0000, elap);
		wait_stat(PDST_STAT_END, 100);
		chk("status", PDST_STAT_END, stat);
		chk("demand", 16'h0032, 16'(odem));
	endtask : t_abort

	task automatic t_delay();
		start(PDST_TYPE_DELAY, PDST_END_STANDBY, 1'h0, 8'h32);
		chk("status", PDST_STAT_RUN, stat);
		chk("standby", 16'h0001, 16'(stby));
		chk("demand", 16'h0000, 16'(odem));
		chk("event", 16'h0008, 16'(evt));
		wait_stat(PDST_STAT_END, 100);
		chk("status", PDST_STAT_END, stat);
		chk("standby", 16'h0000, 16'(stby));
		chk("demand", 16'h0032, 16'(odem));
		chk("event", 16'h0003, 16'(evt));
	endtask : t_delay

	task automatic t_dwell(input pdst_end_t a, input logic c);
		int n;
		start(PDST_TYPE_DWELL, a, c, 8'h00);
		pulse_run();
		chk("armed", PDST_STAT_RUN, stat);
		chk("elapsed", 16'h0000, elap);
		@(posedge i_clock);
		dem <= 8'h32;
		n = 0;
		while (elap !== 16'h0001 && n < 60) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		n = 0;
		while (elap === 16'h0001 && n < 20) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		chk("tick", 16'h0004, 16'(n));
		while (elap !== dur && n < 40) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		@(posedge i_clock);
		#1;
	endtask : t_dwell

	task automatic t_ends();
		t_dwell(PDST_END_STANDBY, 1'h0);
		chk("status", PDST_STAT_END, stat);
		chk("demand", 16'h0000, 16'(odem));
		chk("standby", 16'h0001, 16'(stby));
		chk("off", 16'h0001, 16'(off));
		t_dwell(PDST_END_CONTINUE, 1'h0);
		chk("status", PDST_STAT_END, stat);
		chk("demand", 16'h0032, 16'(odem));
		chk("use2", 16'h0000, 16'(use2));
		t_dwell(PDST_END_SP2, 1'h0);
		chk("status", PDST_STAT_RUN, stat);
		chk("use2", 16'h0001, 16'(use2));
		chk("ramp", 16'h0001, 16'(ramp));
		wait_stat(PDST_STAT_END, 400);
		chk("status", PDST_STAT_END, stat);
		t_dwell(PDST_END_RESET, 1'h1);
		chk("status", PDST_STAT_RESET, stat);
		chk("use2", 16'h0001, 16'(use2));
		// Without rate limit the switch ends one cycle later
		@(posedge i_clock);
		rate <= 1'h0;
		t_dwell(PDST_END_SP2, 1'h0);
		chk("ramp", 16'h0000, 16'(ramp));
		@(posedge i_clock);
		#1;
		chk("status", PDST_STAT_END, stat);
		chk("use2", 16'h0001, 16'(use2));
	endtask : t_ends

	task automatic t_soft();
		@(posedge i_clock);
		evt_en <= 4'h7;
		evt_end <= 4'hc;
		start(PDST_TYPE_SOFT, PDST_END_STANDBY, 1'h0, 8'h50);
		chk("status", PDST_STAT_RUN, stat);
		chk("demand", 16'h0019, 16'(odem));
		chk("event", 16'h0003, 16'(evt));
		wait_stat(PDST_STAT_END, 200);
		chk("status", PDST_STAT_END, stat);
		chk("demand", 16'h0050, 16'(odem));
		chk("event", 16'h0004, 16'(evt));
	endtask : t_soft

	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		t_off();
		t_delay();
		t_abort();
		t_ends();
		t_soft();
		complete_run();
	end
endmodule : pdst_timer_bench
